// ### src/pulse_count_voltage_select.sv
// Single-wire pulse-count decoder selecting the regulator set-point
// Operation
// - Rising edges in a burst are counted; the count indexes the register.
// - After power-up the set-point is the 1.8 V default.
// - A burst of exactly one edge leaves the set-point unchanged.
// - Counts 2 to 28 give 0.65 V to 1.95 V in 50 mV steps.
// - Counts 29 to 32 all give the 2.00 V maximum.
// - Count 25 is the default register and reselects 1.8 V.
// - The new set-point applies only after the line stays high for latch time.
// - Low beyond off time disables output and restores the default.
`timescale 1ns/1ps
module pulse_count_voltage_select #(
    parameter int unsigned LATCH_CYC = pcv_pkg::LATCH_HOLD_CYC,
    parameter int unsigned OFF_CYC   = pcv_pkg::OFF_TIME_CYC
) (
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    input  wire logic                       en_set,
    output logic                            out_enable_q,
    output logic [pcv_pkg::CODE_W-1:0]      setpoint_q,
    output logic                            applied_q
);
    import pcv_pkg::*;

    // Maps a burst length to a set-point code, clamping the top registers
    function automatic logic [CODE_W-1:0] count_to_code(
        input logic [CNT_W-1:0] n
    );
        logic [CNT_W-1:0] m;
        m = (n >= EDGES_CLAMP) ? EDGES_CLAMP : n;
        return CODE_W'(m - CNT_W'(1));
    endfunction : count_to_code

    logic                 rst_meta_q;
    logic                 rst_n;
    logic                 en_q;
    logic                 rise;
    logic [CNT_W-1:0]     edges_q;
    hold_timer_if         lat_if ();
    hold_timer_if         off_if ();

    // Reset release is synchronised; assertion stays asynchronous
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 1'b0;
        end else begin
            en_q <= en_set;
        end
    end

    // Edges closer than one clock are lost; host rate limit keeps margin
    assign rise = en_set && !en_q;

    // Latch timer restarts at every edge since run drops in the edge cycle
    assign lat_if.run = en_set && en_q && (edges_q != '0);
    assign off_if.run = !en_set && !en_q;

    hold_timer #(.LIMIT(LATCH_CYC)) u_latch_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .tmr   (lat_if)
    );

    hold_timer #(.LIMIT(OFF_CYC)) u_off_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .tmr   (off_if)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edges_q <= '0;
        end else if (lat_if.done || off_if.done) begin
            edges_q <= '0;
        end else if (rise && edges_q != EDGES_SAT) begin
            edges_q <= edges_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            setpoint_q <= CODE_DEFAULT;
        end else if (off_if.done) begin
            setpoint_q <= CODE_DEFAULT;
        end else if (lat_if.done && edges_q != EDGES_KEEP) begin
            setpoint_q <= count_to_code(edges_q);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            applied_q <= 1'b0;
        end else begin
            applied_q <= lat_if.done;
        end
    end

    // Output follows the line high, but only a long low turns it off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_enable_q <= 1'b0;
        end else if (off_if.done) begin
            out_enable_q <= 1'b0;
        end else if (rise) begin
            out_enable_q <= 1'b1;
        end
    end

    // Cycles the line has held one level; feeds the timing checks only.
    // Kept apart from the timers so a timer slip cannot hide itself.
    logic [TMR_W-1:0] level_run_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_run_q <= '0;
        end else if (en_set != en_q) begin
            level_run_q <= '0;
        end else if (level_run_q != '1) begin
            level_run_q <= level_run_q + TMR_W'(1);
        end
    end

    property p_latch_wait;
        @(posedge clk) disable iff (!rst_n)
        lat_if.done |-> level_run_q == TMR_W'(LATCH_CYC - 1);
    endproperty
    a_latch_wait: assert property (p_latch_wait)
        else $error("latch fired before the hold time ran out");

    property p_latch_due;
        @(posedge clk) disable iff (!rst_n)
        (en_set && en_q && edges_q != '0
            && level_run_q == TMR_W'(LATCH_CYC - 1)) |-> lat_if.done;
    endproperty
    a_latch_due: assert property (p_latch_due)
        else $error("latch missing after the hold time");

    property p_off_wait;
        @(posedge clk) disable iff (!rst_n)
        off_if.done |-> level_run_q == TMR_W'(OFF_CYC - 1);
    endproperty
    a_off_wait: assert property (p_off_wait)
        else $error("disable fired before the off time ran out");

    property p_off_due;
        @(posedge clk) disable iff (!rst_n)
        (!en_set && !en_q
            && level_run_q == TMR_W'(OFF_CYC - 1)) |-> off_if.done;
    endproperty
    a_off_due: assert property (p_off_due)
        else $error("disable missing after the off time");

    property p_applied_pulse;
        @(posedge clk) disable iff (!rst_n)
        applied_q |=> !applied_q;
    endproperty
    a_applied_pulse: assert property (p_applied_pulse)
        else $error("latch strobe held longer than one cycle");

    property p_count_edge;
        @(posedge clk) disable iff (!rst_n)
        (rise && edges_q < EDGES_SAT && !lat_if.done && !off_if.done)
            |=> edges_q == $past(edges_q) + CNT_W'(1);
    endproperty
    a_count_edge: assert property (p_count_edge)
        else $error("rising edge not counted");

    property p_reset_default;
        @(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> setpoint_q == CODE_DEFAULT && !out_enable_q;
    endproperty
    a_reset_default: assert property (p_reset_default)
        else $error("set-point not default after reset");

    property p_single_edge;
        @(posedge clk) disable iff (!rst_n)
        (lat_if.done && edges_q == EDGES_KEEP) |=> $stable(setpoint_q);
    endproperty
    a_single_edge: assert property (p_single_edge)
        else $error("single edge changed set-point");

    property p_linear;
        @(posedge clk) disable iff (!rst_n)
        (lat_if.done && edges_q > EDGES_KEEP && edges_q < EDGES_CLAMP)
            |=> setpoint_q == CODE_W'($past(edges_q) - CNT_W'(1));
    endproperty
    a_linear: assert property (p_linear)
        else $error("linear set-point mapping wrong");

    property p_clamp_max;
        @(posedge clk) disable iff (!rst_n)
        (lat_if.done && !off_if.done && edges_q >= EDGES_CLAMP)
            |=> setpoint_q == CODE_MAX;
    endproperty
    a_clamp_max: assert property (p_clamp_max)
        else $error("top counts not clamped to maximum");

    property p_default_25;
        @(posedge clk) disable iff (!rst_n)
        (lat_if.done && edges_q == CNT_W'(25)) |=> setpoint_q == CODE_DEFAULT;
    endproperty
    a_default_25: assert property (p_default_25)
        else $error("count 25 did not select default");

    property p_only_on_latch;
        @(posedge clk) disable iff (!rst_n)
        !$stable(setpoint_q) |-> applied_q || !out_enable_q;
    endproperty
    a_only_on_latch: assert property (p_only_on_latch)
        else $error("set-point changed without latch or disable");

    property p_latch_after_hold;
        @(posedge clk) disable iff (!rst_n)
        (rise ##1 (en_set && !rise) [*8]) |-> !lat_if.done || LATCH_CYC <= 8;
    endproperty
    a_latch_after_hold: assert property (p_latch_after_hold)
        else $error("latch fired before hold time");

    property p_off;
        @(posedge clk) disable iff (!rst_n)
        off_if.done |=> !out_enable_q && setpoint_q == CODE_DEFAULT
            && edges_q == '0;
    endproperty
    a_off: assert property (p_off)
        else $error("long low did not disable and restore");

    property p_clear;
        @(posedge clk) disable iff (!rst_n)
        lat_if.done |=> edges_q == '0 && applied_q;
    endproperty
    a_clear: assert property (p_clear)
        else $error("edge counter not cleared after latch");
endmodule : pulse_count_voltage_select

// ### src/pcv_pkg.sv
// Constants for the pulse-count voltage select block
package pcv_pkg;
    localparam int unsigned CLK_PERIOD_NS       = 40;
    // Longest time the device may wait before applying a burst
    localparam int unsigned LATCH_HOLD_TIME_NS  = 500000;
    localparam int unsigned LATCH_HOLD_CYC      =
        LATCH_HOLD_TIME_NS / CLK_PERIOD_NS;
    // Low time that is surely a disable request
    localparam int unsigned OFF_TIME_NS         = 500000;
    localparam int unsigned OFF_TIME_CYC        =
        (OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned TMR_W               = 24;
    localparam int unsigned CNT_W               = 6;
    localparam int unsigned CODE_W              = 5;

    // Set-point code: volts = 0.60 + 0.05 * code; code = register - 1, capped at 28 (2.00 V) for registers 29 to 32
    localparam logic [CODE_W-1:0] CODE_DEFAULT  = 5'h18;
    localparam logic [CODE_W-1:0] CODE_MAX      = 5'h1c;
    localparam logic [CNT_W-1:0]  EDGES_KEEP    = 6'h01;
    localparam logic [CNT_W-1:0]  EDGES_CLAMP   = 6'h1d;
    localparam logic [CNT_W-1:0]  EDGES_SAT     = 6'h20;
endpackage : pcv_pkg

// ### src/hold_timer_if.sv
// Run and expiry handshake between the decoder and a hold timer
`timescale 1ns/1ps
interface hold_timer_if;
    logic run;
    logic done;
    modport owner (output run, input done);
    modport timer (input run, output done);
endinterface : hold_timer_if

// ### src/hold_timer.sv
// Counts cycles of a run level and flags the cycle the limit is reached
`timescale 1ns/1ps
module hold_timer #(
    parameter int unsigned LIMIT = 16
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    hold_timer_if.timer      tmr
);
    import pcv_pkg::*;

    logic [TMR_W-1:0] cnt_q;
    logic [TMR_W-1:0] cnt_d;

    // Count stops at LIMIT, one past the done value, so done fires once per run period
    always_comb begin
        cnt_d = cnt_q;
        if (!tmr.run) begin
            cnt_d = '0;
        end else if (cnt_q != TMR_W'(LIMIT)) begin
            cnt_d = cnt_q + TMR_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign tmr.done = tmr.run && (cnt_q == TMR_W'(LIMIT - 1));
endmodule : hold_timer

// ### dv/host_pulser.sv
// Host model driving pulse bursts on the enable/set line
`timescale 1ns/1ps
module host_pulser (
    input  wire logic clk,
    output logic      en_set
);
    initial en_set = 1'b0;
    // 25-cycle period keeps the edge rate at 1 MHz; the low phase stays
    // under the off threshold so a burst is never taken as a disable
    task automatic pulse_burst(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk) en_set <= 1'b0;
            repeat (12) @(posedge clk);
            en_set <= 1'b1;
            repeat (12) @(posedge clk);
        end
    endtask : pulse_burst
    task automatic go_low(input int cyc);
        @(posedge clk) en_set <= 1'b0;
        repeat (cyc) @(posedge clk);
    endtask : go_low
endmodule : host_pulser

// ### dv/pulse_count_voltage_select_tb_top.sv
// Self-checking bench for the pulse-count voltage select block
`timescale 1ns/1ps
module pulse_count_voltage_select_tb_top;
    import pcv_pkg::*;
    localparam int unsigned LATCH = 16;
    localparam int unsigned OFF   = 20;
    logic              clk;
    logic              arst_n;
    logic              en_set;
    logic              out_enable_q;
    logic [CODE_W-1:0] setpoint_q;
    logic              applied_q;
    logic [CODE_W-1:0] cur;
    int                miscompares;
    int                samples_checked;
    int                corners[7] = '{2, 1, 28, 25, 29, 33, 32};

    pulse_count_voltage_select #(.LATCH_CYC(LATCH), .OFF_CYC(OFF))
        i_pulse_count_voltage_select (.clk(clk), .arst_n(arst_n),
        .en_set(en_set), .out_enable_q(out_enable_q),
        .setpoint_q(setpoint_q), .applied_q(applied_q));
    host_pulser i_host_pulser (.clk(clk), .en_set(en_set));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [CODE_W-1:0] exp_code(input int n,
                                                   input logic [4:0] old);
        if (n == 1) return old;
        if (n >= 29) return 5'h1c;
        return CODE_W'(n - 1);
    endfunction : exp_code

    task automatic chk(input string what, input logic [4:0] exp,
                       input logic [4:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic summarize();
        $display("Checked %0d, mismatches %0d", samples_checked,
                 miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // Line is still short of the latch time when the burst task returns,
    // so the old set-point must still stand at that point
    task automatic run_burst(input int n);
        int k;
        i_host_pulser.pulse_burst(n);
        #1;
        chk("held code", cur, setpoint_q);
        chk("enable", 5'h01, 5'(out_enable_q));
        k = 0;
        while (applied_q !== 1'b1 && k < 40) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (applied_q !== 1'b1) begin
            miscompares++;
            summarize();
        end
        // Burst task returns 11 edges after the last rise; the latch
        // strobe is seen LATCH edges after that rise
        chk("latch delay", 5'(LATCH - 11), 5'(k));
        cur = exp_code(n, cur);
        chk("code", cur, setpoint_q);
        @(posedge clk);
        #1;
        chk("applied pulse", 5'h00, 5'(applied_q));
        $display("Burst of %0d edges done", n);
    endtask : run_burst

    initial begin
        arst_n = 1'b0;
        miscompares = 0;
        samples_checked = 0;
        cur = 5'h18;
        void'($urandom(75));
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("reset code", 5'h18, setpoint_q);
        foreach (corners[i]) run_burst(corners[i]);
        repeat (8) run_burst(1 + ($urandom % 32));
        i_host_pulser.go_low(OFF + 4);
        #1;
        chk("off enable", 5'h00, 5'(out_enable_q));
        chk("off code", 5'h18, setpoint_q);
        $display("Disable test done");
        cur = 5'h18;
        run_burst(1);
        run_burst(3);
        summarize();
    end
endmodule : pulse_count_voltage_select_tb_top
